// [rtl/rlcc_pkg.sv]
// constants, register map and state types of the reset, low-power and clock controller
package rlcc_pkg;
	// bus clock and derived timing
	localparam int CLK_FREQ_HZ = 10_000_000;
	localparam int CLK_FREQ_MHZ = CLK_FREQ_HZ / 1_000_000;
	// least time without an external clock toggle before it is declared dead
	localparam int MON_TIMEOUT_NS = 2000;
	localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_NS * CLK_FREQ_MHZ + 999) / 1000;
	// least dead time with the system clock gated around a source change
	localparam int SWITCH_GAP_NS = 300;
	localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS * CLK_FREQ_MHZ + 999) / 1000;
	// internal rc oscillator start-up time after stop mode
	localparam int RC_START_NS = 2000;
	localparam int RC_START_CYC = (RC_START_NS * CLK_FREQ_MHZ + 999) / 1000;
	// source frequencies and domain ceilings, in mhz
	localparam int RC_OSC_MHZ = 8;
	localparam int EXT_MIN_MHZ = 4;
	localparam int EXT_MAX_MHZ = 32;
	localparam int AHB_MAX_MHZ = 72;
	localparam int APB2_MAX_MHZ = 72;
	localparam int APB1_MAX_MHZ = 36;
	// byte offsets of the registers
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_CFG = 5'h04;
	localparam logic [4:0] REG_MODE = 5'h08;
	localparam logic [4:0] REG_STATUS = 5'h0c;
	localparam logic [4:0] REG_IRQ_STAT = 5'h10;
	localparam logic [4:0] REG_IRQ_CLR = 5'h14;
	localparam logic [4:0] REG_IRQ_EN = 5'h18;
	// ctrl fields
	localparam int CTRL_EXT_SEL = 0;
	localparam int CTRL_PLL_EN = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// cfg fields: divider codes, divide by 2**code
	localparam int CFG_AHB_LSB = 0;
	localparam int CFG_APB2_LSB = 2;
	localparam int CFG_APB1_LSB = 4;
	localparam logic [5:0] CFG_RESET = 6'h00;
	// mode command bits
	localparam int MODE_SLEEP = 0;
	localparam int MODE_STOP = 1;
	// interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_EXT_FAIL = 0;
	localparam int IRQ_PLL_LOST = 1;
	localparam int IRQ_PLL_READY = 2;
	localparam int IRQ_STOP_WAKE = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
	// power and clock source states
	typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_STOP, PWR_WAKE} rlcc_pwr_type;
	typedef enum logic [1:0] {CLK_RC, CLK_GAP_TO_EXT, CLK_EXT, CLK_GAP_TO_RC} rlcc_clk_type;
	// smallest divider code that keeps src/2**code under the ceiling
	function automatic logic [1:0] rlcc_min_code(input int src_mhz, input int max_mhz);
		logic [1:0] code;
		code = 2'h3;
		for (int i = 3; i >= 0; i--) begin
			if ((src_mhz >> i) <= max_mhz) begin
				code = 2'(i);
			end
		end
		return code;
	endfunction
endpackage

// [rtl/rlcc_prescaler.sv]
// clock-enable prescaler dividing an input tick by 2**code
module rlcc_prescaler #(
	parameter int CODE_W = 2,
	parameter int CNT_W = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// input tick and divider code
	input wire logic tick_in,
	input wire logic [CODE_W-1:0] div_code,
	// divided one-cycle tick
	output logic tick_out
);
	logic [CNT_W-1:0] cnt_q; // input ticks seen in this period
	logic [CNT_W-1:0] last; // count at which a period ends

	assign last = CNT_W'((1 << div_code) - 1);

	// count ticks; the output pulse is registered to keep it glitch free
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= tick_in && (cnt_q >= last);
			if (tick_in) begin
				// a code lowered mid-period ends the period at once
				cnt_q <= (cnt_q >= last) ? '0 : cnt_q + 1'b1;
			end
		end
	end
endmodule

// [rtl/rlcc_top.sv]
// reset, low-power mode and system clock controller with avalon register slave
// How it works
// - device held in reset while pin low
// - sleep stops cpu clock only, irq wakes
// - stop gates core clocks and all oscillators
// - any event line wakes from stop
// - any reset selects internal rc oscillator
// - external clock selectable, monitored while used
// - dead external clock falls back to rc
// - clock failure interrupt only when enabled
// - pll input path events raise interrupts
// - prescalers keep ahb, apb2, apb1 under ceilings
module rlcc_top
	import rlcc_pkg::*;
#(
	parameter int N_USART = 3,
	parameter int N_I2C = 2,
	parameter int N_COMP = 2,
	parameter int EXT_CLK_MHZ = rlcc_pkg::EXT_MAX_MHZ
) (
	// clock and asynchronous reset
	input wire logic clk,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// external reset pin and resulting device reset
	input wire logic ext_reset_pin_n,
	output logic device_reset_n,
	// wakeup sources, asynchronous
	input wire logic [15:0] ext_event_lines,
	input wire logic supply_voltage_detector,
	input wire logic [N_USART-1:0] usart_wake,
	input wire logic [N_I2C-1:0] i2c_wake,
	input wire logic cec_wake,
	input wire logic [N_COMP-1:0] analog_comparators,
	input wire logic rtc_alarm,
	// peripheral interrupt, same clock
	input wire logic periph_irq,
	// oscillator status, asynchronous
	input wire logic ext_clk_toggle,
	input wire logic pll_lock,
	// oscillator and pll enables
	output logic rc_osc_en,
	output logic xtal_osc_en,
	output logic pll_en,
	// system clock selection and gates
	output logic sys_clk_sel,
	output logic sys_clk_gate,
	output logic core_clk_run,
	output logic cpu_clk_en,
	output logic ahb_clk_en,
	output logic apb2_clk_en,
	output logic apb1_clk_en,
	// interrupt to cpu
	output logic irq
);
	import rlcc_pkg::*;

	localparam int N_WAKE = 16 + 1 + N_USART + N_I2C + 1 + N_COMP + 1;
	localparam int N_ASYNC = N_WAKE + 3; // wake lines, reset pin, ext toggle, pll lock

	// synchroniser chain of every pin input
	logic [N_ASYNC-1:0] async_in;
	logic [N_ASYNC-1:0] sync1_q;
	logic [N_ASYNC-1:0] sync2_q;
	logic [N_WAKE-1:0] wake_s;
	logic pin_s; // synchronised reset pin level
	logic toggle_s;
	logic lock_s;
	logic toggle_prev_q; // for edge detection of the ext toggle
	logic lock_prev_q;
	logic dev_rst; // device held in reset by the pin
	logic wake_any;

	// control state
	rlcc_pwr_type pwr_q;
	rlcc_clk_type clk_q;
	logic [7:0] pwr_cnt_q; // rc start-up wait
	logic [3:0] gap_cnt_q; // dead time around a source change
	logic [1:0] ctrl_q;
	logic [5:0] cfg_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic [IRQ_W-1:0] irq_set;
	logic sel_q;
	// clock monitor
	logic [7:0] mon_cnt_q;
	logic edge_seen_q;
	logic ext_ok;
	logic mon_fail;
	// bus
	logic ack_q;
	logic wr_en;
	logic [31:0] rd_mux;
	logic [2:0] word_idx;
	// prescaler chain
	logic sys_tick;
	logic [1:0] ahb_code;
	logic [1:0] apb2_code;
	logic [1:0] apb1_code;

	assign async_in = {pll_lock, ext_clk_toggle, ext_reset_pin_n, rtc_alarm, analog_comparators,
		cec_wake, i2c_wake, usart_wake, supply_voltage_detector, ext_event_lines};

	// two-stage synchronisers for everything arriving from the pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	assign wake_s = sync2_q[N_WAKE-1:0];
	assign pin_s = sync2_q[N_WAKE];
	assign toggle_s = sync2_q[N_WAKE+1];
	assign lock_s = sync2_q[N_WAKE+2];
	// pin low keeps the device in reset
	assign dev_rst = !pin_s;
	assign device_reset_n = pin_s;
	assign wake_any = |wake_s;

	// edge history of the synchronised oscillator signals
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			toggle_prev_q <= 1'b0;
			lock_prev_q <= 1'b0;
		end else begin
			toggle_prev_q <= toggle_s;
			lock_prev_q <= lock_s;
		end
	end

	// external clock activity monitor, runs whenever the crystal is on
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mon_cnt_q <= '0;
			edge_seen_q <= 1'b0;
		end else if (dev_rst || !xtal_osc_en) begin
			// restart the watch when the oscillator is off
			mon_cnt_q <= '0;
			edge_seen_q <= 1'b0;
		end else if (toggle_s != toggle_prev_q) begin
			mon_cnt_q <= '0;
			edge_seen_q <= 1'b1;
		end else if (mon_cnt_q != 8'(MON_TIMEOUT_CYC)) begin
			mon_cnt_q <= mon_cnt_q + 8'h01;
		end
	end

	assign ext_ok = edge_seen_q && (mon_cnt_q != 8'(MON_TIMEOUT_CYC));
	// only a failure while the external clock is in use forces fallback
	assign mon_fail = (clk_q == CLK_EXT) && !ext_ok;

	// avalon handshake: one wait cycle, then the access completes
	assign avs_waitrequest = !ack_q;
	assign wr_en = avs_write && ack_q;
	assign word_idx = avs_address[4:2];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
		end
	end

	// read mux; unmapped and write-only words read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			REG_CTRL: rd_mux[1:0] = ctrl_q;
			REG_CFG: rd_mux[5:0] = cfg_q;
			REG_MODE: rd_mux[1:0] = pwr_q;
			REG_STATUS: rd_mux[5:0] = {lock_s, ext_ok, sel_q, sys_clk_gate, pwr_q == PWR_WAKE,
				pin_s};
			REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
			REG_IRQ_EN: rd_mux[IRQ_W-1:0] = irq_en_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data is captured during the wait cycle and stands at completion
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			avs_readdata <= rd_mux;
		end
	end

	// ctrl register; hardware clears the external select on failure or stop wake
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (dev_rst) begin
			// every reset returns to the rc source
			ctrl_q <= CTRL_RESET;
		end else begin
			if (wr_en && avs_address == REG_CTRL) begin
				ctrl_q <= avs_writedata[1:0];
			end
			// the fallback wins over a simultaneous software write
			if (mon_fail || (pwr_q == PWR_STOP && wake_any)) begin
				ctrl_q[CTRL_EXT_SEL] <= 1'b0;
			end
		end
	end

	// prescaler configuration and interrupt enables
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q <= CFG_RESET;
			irq_en_q <= IRQ_RESET;
		end else if (dev_rst) begin
			cfg_q <= CFG_RESET;
			irq_en_q <= IRQ_RESET;
		end else if (wr_en) begin
			if (avs_address == REG_CFG) begin
				cfg_q <= avs_writedata[5:0];
			end
			if (avs_address == REG_IRQ_EN) begin
				irq_en_q <= avs_writedata[IRQ_W-1:0];
			end
		end
	end

	// power mode machine
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwr_q <= PWR_RUN;
			pwr_cnt_q <= '0;
		end else if (dev_rst) begin
			pwr_q <= PWR_RUN;
			pwr_cnt_q <= '0;
		end else begin
			case (pwr_q)
				PWR_RUN: begin
					// stop takes priority when both bits are written
					if (wr_en && avs_address == REG_MODE && avs_writedata[MODE_STOP]) begin
						pwr_q <= PWR_STOP;
					end else if (wr_en && avs_address == REG_MODE &&
						avs_writedata[MODE_SLEEP]) begin
						pwr_q <= PWR_SLEEP;
					end
				end
				PWR_SLEEP: begin
					// any peripheral interrupt or event line resumes the cpu
					if (periph_irq || wake_any) begin
						pwr_q <= PWR_RUN;
					end
				end
				PWR_STOP: begin
					// event line wakes; rc needs its start-up time first
					if (wake_any) begin
						pwr_q <= PWR_WAKE;
						pwr_cnt_q <= 8'(RC_START_CYC);
					end
				end
				PWR_WAKE: begin
					// hold clocks off until the restarted rc is stable
					if (pwr_cnt_q <= 8'h01) begin
						pwr_q <= PWR_RUN;
					end
					pwr_cnt_q <= pwr_cnt_q - 8'h01;
				end
				default: pwr_q <= PWR_RUN;
			endcase
		end
	end

	// clock source machine, every change passes a closed gate
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clk_q <= CLK_RC;
			sel_q <= 1'b0;
			gap_cnt_q <= '0;
		end else if (dev_rst || pwr_q == PWR_STOP || pwr_q == PWR_WAKE) begin
			// reset and stop leave the rc selected; gate is closed meanwhile
			clk_q <= CLK_RC;
			sel_q <= 1'b0;
			gap_cnt_q <= '0;
		end else begin
			case (clk_q)
				CLK_RC: begin
					// switch only onto a clock already seen running
					if (ctrl_q[CTRL_EXT_SEL] && ext_ok) begin
						clk_q <= CLK_GAP_TO_EXT;
						gap_cnt_q <= 4'(SWITCH_GAP_CYC);
					end
				end
				CLK_GAP_TO_EXT: begin
					// selector flips only at the end of the dead gap
					if (gap_cnt_q <= 4'h1) begin
						clk_q <= ext_ok ? CLK_EXT : CLK_RC;
						sel_q <= ext_ok;
					end
					gap_cnt_q <= gap_cnt_q - 4'h1;
				end
				CLK_EXT: begin
					// failure or deselect starts the return to rc
					if (mon_fail || !ctrl_q[CTRL_EXT_SEL]) begin
						clk_q <= CLK_GAP_TO_RC;
						gap_cnt_q <= 4'(SWITCH_GAP_CYC);
					end
				end
				CLK_GAP_TO_RC: begin
					// same gated gap on the way back
					if (gap_cnt_q <= 4'h1) begin
						clk_q <= CLK_RC;
						sel_q <= 1'b0;
					end
					gap_cnt_q <= gap_cnt_q - 4'h1;
				end
				default: clk_q <= CLK_RC;
			endcase
		end
	end

	// stop gates the core domain and every oscillator; registers keep state
	assign core_clk_run = !dev_rst && (pwr_q == PWR_RUN || pwr_q == PWR_SLEEP);
	assign rc_osc_en = pwr_q != PWR_STOP;
	assign xtal_osc_en = ctrl_q[CTRL_EXT_SEL] && core_clk_run;
	assign pll_en = ctrl_q[CTRL_PLL_EN] && core_clk_run;
	assign sys_clk_sel = sel_q;
	assign sys_clk_gate = core_clk_run && (clk_q == CLK_RC || clk_q == CLK_EXT);
	assign sys_tick = sys_clk_gate;

	// divider codes raised to the least that respects each ceiling
	always_comb begin
		ahb_code = cfg_q[CFG_AHB_LSB +: 2];
		if (ahb_code < rlcc_min_code(sel_q ? EXT_CLK_MHZ : RC_OSC_MHZ, AHB_MAX_MHZ)) begin
			ahb_code = rlcc_min_code(sel_q ? EXT_CLK_MHZ : RC_OSC_MHZ, AHB_MAX_MHZ);
		end
		apb2_code = cfg_q[CFG_APB2_LSB +: 2];
		if (apb2_code < rlcc_min_code((sel_q ? EXT_CLK_MHZ : RC_OSC_MHZ) >> ahb_code,
			APB2_MAX_MHZ)) begin
			apb2_code = rlcc_min_code((sel_q ? EXT_CLK_MHZ : RC_OSC_MHZ) >> ahb_code,
				APB2_MAX_MHZ);
		end
		apb1_code = cfg_q[CFG_APB1_LSB +: 2];
		if (apb1_code < rlcc_min_code((sel_q ? EXT_CLK_MHZ : RC_OSC_MHZ) >> ahb_code,
			APB1_MAX_MHZ)) begin
			apb1_code = rlcc_min_code((sel_q ? EXT_CLK_MHZ : RC_OSC_MHZ) >> ahb_code,
				APB1_MAX_MHZ);
		end
	end

	// ahb tick from the gated system tick, apb ticks from ahb
	rlcc_prescaler u_ahb (
		.clk(clk),
		.resetn(resetn),
		.tick_in(sys_tick),
		.div_code(ahb_code),
		.tick_out(ahb_clk_en)
	);

	rlcc_prescaler u_apb2 (
		.clk(clk),
		.resetn(resetn),
		.tick_in(ahb_clk_en),
		.div_code(apb2_code),
		.tick_out(apb2_clk_en)
	);

	rlcc_prescaler u_apb1 (
		.clk(clk),
		.resetn(resetn),
		.tick_in(ahb_clk_en),
		.div_code(apb1_code),
		.tick_out(apb1_clk_en)
	);

	// cpu loses its clock in sleep while peripherals keep theirs
	assign cpu_clk_en = ahb_clk_en && pwr_q == PWR_RUN && core_clk_run;

	// interrupt events: clock failure, pll input loss and lock, stop wakeup
	always_comb begin
		irq_set = '0;
		// failure is always recorded; the enable decides the line
		irq_set[IRQ_EXT_FAIL] = mon_fail;
		irq_set[IRQ_PLL_LOST] = pll_en && lock_prev_q && !lock_s;
		irq_set[IRQ_PLL_READY] = pll_en && !lock_prev_q && lock_s;
		irq_set[IRQ_STOP_WAKE] = pwr_q == PWR_STOP && wake_any;
	end

	// sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_q <= IRQ_RESET;
		end else if (dev_rst) begin
			irq_stat_q <= IRQ_RESET;
		end else if (wr_en && avs_address == REG_IRQ_CLR) begin
			irq_stat_q <= (irq_stat_q & ~avs_writedata[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	// level interrupt only from enabled bits
	assign irq = |(irq_stat_q & irq_en_q);

	// reset pin low returns rc and run state
	a_reset_state: assert property (@(posedge clk) disable iff (!resetn)
		dev_rst |-> !core_clk_run ##1 (clk_q == CLK_RC && !sel_q && pwr_q == PWR_RUN))
		else $error("reset pin low did not restore rc and run state");

	// failure leaves the external source within a few cycles
	a_fail_fallback: assert property (@(posedge clk) disable iff (!resetn)
		(mon_fail && !dev_rst && pwr_q == PWR_RUN) |=> clk_q == CLK_GAP_TO_RC ##3 !sel_q)
		else $error("external clock failure did not fall back to rc");

	// enabled failure raises the line next cycle
	a_fail_irq_on: assert property (@(posedge clk) disable iff (!resetn)
		(mon_fail && irq_en_q[IRQ_EXT_FAIL] && !dev_rst && !wr_en) |=> irq)
		else $error("enabled clock failure raised no interrupt");

	a_fail_irq_off: assert property (@(posedge clk) disable iff (!resetn)
		(irq_en_q == '0) |-> !irq)
		else $error("interrupt raised with all enables clear");

	// sleep keeps peripherals ticking but the cpu halted
	a_sleep_cpu: assert property (@(posedge clk) disable iff (!resetn)
		(pwr_q == PWR_SLEEP && !dev_rst) |-> (!cpu_clk_en && core_clk_run))
		else $error("sleep mode did not halt only the cpu");

	// stop gates everything of the core domain
	a_stop_gates: assert property (@(posedge clk) disable iff (!resetn)
		(pwr_q == PWR_STOP) |-> (!rc_osc_en && !xtal_osc_en && !pll_en && !sys_clk_gate))
		else $error("stop mode left a clock or oscillator running");

	// an event line leaves stop at the next edge
	a_stop_wake: assert property (@(posedge clk) disable iff (!resetn)
		(pwr_q == PWR_STOP && wake_any && !dev_rst) |=> pwr_q == PWR_WAKE)
		else $error("event line did not wake from stop");

	// wakeup resumes on rc with external select dropped
	a_wake_rc: assert property (@(posedge clk) disable iff (!resetn)
		(pwr_q == PWR_WAKE) |-> (rc_osc_en && !sel_q && !ctrl_q[CTRL_EXT_SEL]))
		else $error("stop wakeup did not restart on the rc oscillator");

	// selector changes only behind a closed gate
	a_switch_gap: assert property (@(posedge clk) disable iff (!resetn)
		$changed(sel_q) |-> !$past(sys_clk_gate))
		else $error("clock source changed while the gate was open");
endmodule

// [tb/rlcc_partner.sv]
// far-side model: reset pin driver, wakeup sources, crystal activity and pll lock
module rlcc_partner (
	// bench clock
	input wire logic clk,
	// crystal enable from the device
	input wire logic xtal_osc_en,
	// bench commands: pin held low, crystal healthy, pll lock, wake levels
	input wire logic pin_hold,
	input wire logic osc_alive,
	input wire logic lock_req,
	input wire logic [25:0] wake_req,
	// reset pin, pulled up when released
	output logic ext_reset_pin_n,
	// wakeup sources
	output logic [15:0] ext_event_lines,
	output logic supply_voltage_detector,
	output logic [2:0] usart_wake,
	output logic [1:0] i2c_wake,
	output logic cec_wake,
	output logic [1:0] analog_comparators,
	output logic rtc_alarm,
	// oscillator status
	output logic ext_clk_toggle = 1'b0,
	output logic pll_lock
);
	timeunit 1ns;
	timeprecision 1ns;
	// pin held low until supply stable, pull-up level once released
	assign ext_reset_pin_n = !pin_hold;
	assign {rtc_alarm, analog_comparators, cec_wake, i2c_wake, usart_wake,
		supply_voltage_detector, ext_event_lines} = wake_req;
	assign pll_lock = lock_req;
	// crystal activity changes each edge only while powered and healthy
	always @(posedge clk) begin
		if (osc_alive && xtal_osc_en) begin
			ext_clk_toggle <= !ext_clk_toggle;
		end
	end
endmodule

// [tb/rlcc_top_tb_top.sv]
// self-checking bench of the reset, low-power and clock controller
module rlcc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rlcc_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, periph_irq = 1'b0;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq, device_reset_n;
	logic [4:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata;
	logic ext_reset_pin_n, supply_voltage_detector, cec_wake, rtc_alarm, ext_clk_toggle;
	logic pll_lock, rc_osc_en, xtal_osc_en, pll_en, sys_clk_sel, sys_clk_gate;
	logic core_clk_run, cpu_clk_en, ahb_clk_en, apb2_clk_en, apb1_clk_en;
	logic [15:0] ext_event_lines;
	logic [2:0] usart_wake;
	logic [1:0] i2c_wake, analog_comparators;
	int n_mismatch = 0, tests_run = 0;
	int c_ahb = 0, c_apb2 = 0, c_apb1 = 0, c_cpu = 0; // running tick counts
	logic sel_q = 1'b0, gate_q = 1'b0, rst_q = 1'b0; // last-cycle copies
	int a, b, c, p; // tick counts of one window
	logic pin_hold = 1'b1, osc_alive = 1'b0, lock_req = 1'b0; // far-side commands
	logic [25:0] wake_req = '0; // one level per wake source
	always #50 clk = !clk;
	rlcc_top #(.N_USART(3), .N_I2C(2), .N_COMP(2)) rlcc_top_i (.clk(clk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ext_reset_pin_n(ext_reset_pin_n),
		.device_reset_n(device_reset_n), .ext_event_lines(ext_event_lines),
		.supply_voltage_detector(supply_voltage_detector), .usart_wake(usart_wake),
		.i2c_wake(i2c_wake), .cec_wake(cec_wake), .analog_comparators(analog_comparators),
		.rtc_alarm(rtc_alarm), .periph_irq(periph_irq), .ext_clk_toggle(ext_clk_toggle),
		.pll_lock(pll_lock), .rc_osc_en(rc_osc_en), .xtal_osc_en(xtal_osc_en),
		.pll_en(pll_en), .sys_clk_sel(sys_clk_sel), .sys_clk_gate(sys_clk_gate),
		.core_clk_run(core_clk_run), .cpu_clk_en(cpu_clk_en), .ahb_clk_en(ahb_clk_en),
		.apb2_clk_en(apb2_clk_en), .apb1_clk_en(apb1_clk_en), .irq(irq));
	rlcc_partner rlcc_partner_i (.clk(clk), .xtal_osc_en(xtal_osc_en), .pin_hold(pin_hold),
		.osc_alive(osc_alive), .lock_req(lock_req), .wake_req(wake_req),
		.ext_reset_pin_n(ext_reset_pin_n), .ext_event_lines(ext_event_lines),
		.supply_voltage_detector(supply_voltage_detector), .usart_wake(usart_wake),
		.i2c_wake(i2c_wake), .cec_wake(cec_wake), .analog_comparators(analog_comparators),
		.rtc_alarm(rtc_alarm), .ext_clk_toggle(ext_clk_toggle), .pll_lock(pll_lock));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= ad;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		chk("avs_waitrequest", 32'h0, avs_waitrequest);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] ad, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, ad, d, x);
	endtask
	task automatic rd_chk(input string nm, input logic [4:0] ad, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, ad, 32'h0, x);
		chk(nm, e, x);
	endtask
	// bounded wait for the selected source, the switch passes a gated gap
	task automatic wait_sel(input logic v);
		int n;
		n = 0;
		while (sys_clk_sel !== v && n < 80) begin
			@(posedge clk);
			n++;
		end
		chk("sys_clk_sel", v, sys_clk_sel);
	endtask
	// tick pulses seen over a window of edges
	task automatic ticks(input int cyc);
		int a0, b0, c0, p0;
		a0 = c_ahb;
		b0 = c_apb2;
		c0 = c_apb1;
		p0 = c_cpu;
		repeat (cyc) @(posedge clk);
		a = c_ahb - a0;
		b = c_apb2 - b0;
		c = c_apb1 - c0;
		p = c_cpu - p0;
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// tick counters and source-change watch
	always @(posedge clk) begin
		c_ahb <= c_ahb + int'(ahb_clk_en);
		c_apb2 <= c_apb2 + int'(apb2_clk_en);
		c_apb1 <= c_apb1 + int'(apb1_clk_en);
		c_cpu <= c_cpu + int'(cpu_clk_en);
		sel_q <= sys_clk_sel;
		gate_q <= sys_clk_gate;
		rst_q <= device_reset_n;
		// gate must be shut before the select moves
		if (rst_q === 1'b1 && device_reset_n === 1'b1 && sys_clk_sel !== sel_q) begin
			chk("gate_at_switch", 32'h0, gate_q);
		end
	end
	// watchdog, about ten times the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		chk("dev_rst_held", 32'h0, device_reset_n);
		pin_hold <= 1'b0;
		repeat (4) @(posedge clk);
		chk("dev_rst_out", 32'h1, device_reset_n);
		chk("sel_reset", 32'h0, sys_clk_sel);
		rd_chk("unmapped", 5'h1c, 32'h0);
		// ahb divider codes, then apb2 and apb1 codes
		for (int k = 0; k < 4; k++) begin
			wr(REG_CFG, 32'(k));
			repeat (8) @(posedge clk);
			ticks(64);
			chk("ahb_ticks", 32'(64 >> k), a);
		end
		wr(REG_CFG, 32'h24);
		repeat (8) @(posedge clk);
		ticks(64);
		chk("apb2_ticks", 32'd32, b);
		chk("apb1_ticks", 32'd16, c);
		// switch to crystal, kill it, with and without the enable
		for (int en = 1; en >= 0; en--) begin
			osc_alive <= 1'b1;
			wr(REG_IRQ_EN, 32'(en));
			wr(REG_CTRL, 32'h1);
			wait_sel(1'b1);
			osc_alive <= 1'b0;
			wait_sel(1'b0);
			repeat (2) @(posedge clk);
			rd_chk("ctrl_fb", REG_CTRL, 32'h0);
			rd_chk("stat_fail", REG_IRQ_STAT, 32'h1);
			chk("irq_fail", 32'(en), irq);
			wr(REG_IRQ_CLR, 32'h1);
			@(posedge clk);
			chk("irq_clr", 32'h0, irq);
		end
		// pll lock gained then lost
		wr(REG_IRQ_EN, 32'h6);
		wr(REG_CTRL, 32'h2);
		lock_req <= 1'b1;
		repeat (5) @(posedge clk);
		rd_chk("pll_ready", REG_IRQ_STAT, 32'h4);
		chk("irq_pll", 32'h1, irq);
		lock_req <= 1'b0;
		repeat (5) @(posedge clk);
		rd_chk("pll_lost", REG_IRQ_STAT, 32'h6);
		wr(REG_IRQ_CLR, 32'h6);
		// sleep halts cpu ticks only, a peripheral irq ends it
		wr(REG_MODE, 32'h1);
		rd_chk("mode_sleep", REG_MODE, 32'h1);
		ticks(16);
		chk("sleep_cpu", 32'd0, p);
		chk("sleep_ahb", 32'd16, a);
		periph_irq <= 1'b1;
		@(posedge clk);
		periph_irq <= 1'b0;
		repeat (3) @(posedge clk);
		rd_chk("mode_run", REG_MODE, 32'h0);
		ticks(16);
		chk("run_cpu", 32'd16, p);
		// stop entered first on crystal and pll, then on rc and pll, each wake source in turn
		osc_alive <= 1'b1;
		wr(REG_CTRL, 32'h3);
		wait_sel(1'b1);
		for (int i = 0; i < 26; i++) begin
			wr(REG_MODE, 32'h2);
			repeat (3) @(posedge clk);
			chk("stop_clks", 32'h0, {rc_osc_en, xtal_osc_en, pll_en, core_clk_run});
			rd_chk("mode_stop", REG_MODE, 32'h2);
			wake_req[i] <= 1'b1;
			repeat (4) @(posedge clk);
			wake_req[i] <= 1'b0;
			repeat (RC_START_CYC + 8) @(posedge clk);
			rd_chk("mode_woken", REG_MODE, 32'h0);
			chk("wake_src", 32'h2, {rc_osc_en, sys_clk_sel});
		end
		rd_chk("cfg_kept", REG_CFG, 32'h24);
		rd_chk("ctrl_wake", REG_CTRL, 32'h2);
		rd_chk("stat_wake", REG_IRQ_STAT, 32'h8);
		// pin reset while on the crystal
		wr(REG_CTRL, 32'h1);
		wait_sel(1'b1);
		pin_hold <= 1'b1;
		repeat (4) @(posedge clk);
		chk("pin_rst", 32'h0, {device_reset_n, sys_clk_sel});
		rd_chk("ctrl_rst", REG_CTRL, 32'h0);
		pin_hold <= 1'b0;
		repeat (4) @(posedge clk);
		chk("pin_out", 32'h2, {device_reset_n, sys_clk_sel});
		rd_chk("status", REG_STATUS, 32'h5);
		report_and_stop();
	end
endmodule
